// *** vme_glue_pkg.sv ***
// Purpose: shared constants and carrier types for the slave decode and master glue
// Assumes: one 100 MHz clock; bus inputs already synchronous to it
// Notes:   all bus strobes active low, named with _n
//
// Summary of operation
// - base match needs strobe, no iack, short io
// - board selected needs base match and data strobe
// - latch a8..a1 at new slave cycle start
// - a8 low selects dma controller chip
// - dma controller unused locations still acknowledge
// - a8,a4 high with lower strobe select gpib
// - gpib odd bytes only; upper byte ones
// - carry byte forces auxiliary mode register select
// - a4 low: a2 picks config one/two
// - config registers write-only, reads return ones
// - board selected holds until strobes released
// - unmatched window locations get no acknowledge
// - divide system clock by two for chips
// - onboard reset from system reset or bit
// - reset bits and decode only system reset
// - bus error while owned to exception input
// - hold data drive while old ack stands
// - drive address, modifier, iack, lword when owned
// - upper address latched by upper address strobe
// - dma write ored with carry byte force
// - dma data strobes gated by timing output
// - 16-bit access to 8-bit register undefined
// - upper byte select steers gpib data lane
package vme_glue_pkg;
    localparam logic [5:0] AM_SHORT_SUP    = 6'h2D;
    localparam logic [5:0] AM_SHORT_USER   = 6'h29;
    localparam logic [5:0] AM_MASTER_DEF   = 6'h3D;
    localparam logic [2:0] AUX_MODE_SEL    = 3'h5;
    localparam logic [7:0] ALL_ONES_BYTE   = 8'hFF;
    localparam int         A8_POS          = 7;
    localparam int         A4_POS          = 3;
    localparam int         A2_POS          = 1;
    localparam int         LMR_POS         = 0;
    localparam int         SFL_POS         = 1;
    localparam logic [7:0] CFG_RESET       = 8'h00;
    localparam int         CLK_DIV         = 2;

    typedef struct packed {
        logic        as_n;
        logic        ds0_n;
        logic        ds1_n;
        logic        iack_n;
        logic        write_n;
        logic [5:0]  am;
        logic [15:1] addr;
    } slave_req_t;

    typedef struct packed {
        logic        dma_sel_n;
        logic        gpib_sel_n;
        logic        config_reg_one_sel_n;
        logic        config_reg_two_sel_n;
        logic [2:0]  gpib_rs;
    } selects_t;
endpackage

// *** vme_clock_divider.sv ***
// Purpose: divide the system clock to a one-cycle enable
// Assumes: clock is the only clock
// Notes:   enable replaces the slower chip clock
module vme_clock_divider
    import vme_glue_pkg::*;
#(
    parameter int DIV = CLK_DIV
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // enable out
    output logic      tick
);
    logic [$clog2(DIV+1)-1:0] count;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == $bits(count)'(DIV - 1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// *** vme_slave_decode.sv ***
// Purpose: address match and register select decode for slave cycles
// Assumes: base jumpers are static
// Notes:   purely combinational; the top registers results
module vme_slave_decode
    import vme_glue_pkg::*;
(
    // bus view
    input  wire vme_glue_pkg::slave_req_t req,
    input  wire logic [15:9]               base,
    input  wire logic [8:1]                held_addr,
    input  wire logic                      carry_byte_force,
    input  wire logic                      selected,
    // results
    output logic                           base_match,
    output vme_glue_pkg::selects_t         sel
);
    always_comb begin
        base_match = !req.as_n && req.iack_n &&
                     (req.am == AM_SHORT_SUP || req.am == AM_SHORT_USER) &&
                     (req.addr[15:9] == base);
        sel.dma_sel_n  = !(selected && !held_addr[8]);
        sel.gpib_sel_n = !(selected && held_addr[8] && held_addr[4] && !req.ds0_n);
        sel.config_reg_one_sel_n = !(selected && held_addr[8] && !held_addr[4] && !held_addr[2]);
        sel.config_reg_two_sel_n = !(selected && held_addr[8] && !held_addr[4] && held_addr[2]);
        sel.gpib_rs    = carry_byte_force ? AUX_MODE_SEL : held_addr[3:1];
    end
endmodule

// *** vme_slave_decode_and_master_glue.sv ***
// Purpose: slave decode, configuration registers, reset and master glue
// Assumes: timing state machine and chips are outside; their strobes arrive as ports
// Notes:   every output is a flip-flop, so all paths add at least one cycle
module vme_slave_decode_and_master_glue
    import vme_glue_pkg::*;
(
    // clock and system reset
    input  wire logic                      clock,
    input  wire logic                      reset,
    // slave side of bus
    input  wire vme_glue_pkg::slave_req_t  slave_req,
    input  wire logic [15:0]               data_in,
    input  wire logic                      dtack_in_n,
    input  wire logic                      berr_in_n,
    input  wire logic [15:9]               base_jumpers,
    input  wire logic                      local_ack_n,
    // dma controller side
    input  wire logic                      bus_owned_n,
    input  wire logic                      upper_addr_strobe_n,
    input  wire logic [15:0]               dma_mux_bus,
    input  wire logic [7:1]                dma_low_addr,
    input  wire logic                      dma_write_n,
    input  wire logic                      upper_data_strobe_n,
    input  wire logic                      lower_data_strobe_n,
    input  wire logic                      upper_byte_select_n,
    input  wire logic                      timing_strobe_gate,
    input  wire logic                      carry_byte_force,
    input  wire logic [7:0]                dma_ctrl_data,
    input  wire logic [7:0]                gpib_data,
    // decode outputs
    output logic                           board_selected_n,
    output vme_glue_pkg::selects_t         selects,
    output logic [8:1]                     held_addr,
    // slave read data
    output logic [15:0]                    read_data,
    output logic                           read_data_oe_n,
    // configuration registers
    output logic [7:0]                     config_reg_one,
    output logic [7:0]                     config_reg_two,
    output logic                           onboard_reset,
    output logic                           chip_clock_tick,
    // master outputs
    output logic [23:1]                    master_addr,
    output logic [5:0]                     master_am,
    output logic                           master_iack_n,
    output logic                           master_lword_n,
    output logic                           master_addr_oe_n,
    output logic                           master_write_n,
    output logic                           master_ds0_n,
    output logic                           master_ds1_n,
    output logic                           master_ds_oe_n,
    output logic                           control_dir_out,
    output logic [15:0]                    master_data,
    output logic                           master_data_oe_n,
    output logic                           bus_exception_input
);
    import vme_glue_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic          base_match;
    logic          selected;
    logic          prev_ack;
    selects_t      next_sel;
    logic [23:16]  upper_latch;
    logic [15:8]   mid_latch;
    logic          cycle_busy;

    assign selected = !board_selected_n;

    vme_clock_divider #(.DIV(CLK_DIV)) u_div (
        .clock (clock),
        .reset (reset),
        .tick  (chip_clock_tick)
    );

    vme_slave_decode u_dec (
        .req              (slave_req),
        .base             (base_jumpers),
        .held_addr        (held_addr),
        .carry_byte_force (carry_byte_force),
        .selected         (selected),
        .base_match       (base_match),
        .sel              (next_sel)
    );

    ////////////////////////////////////////////////////////////////////////
    // address holding latch, system reset only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            held_addr <= '0;
            prev_ack  <= 1'b0;
        end else begin
            prev_ack <= !dtack_in_n;
            if (!slave_req.as_n && !prev_ack && !cycle_busy)
                held_addr <= slave_req.addr[8:1];
        end
    end

    // board selected, held till strobes and ack released
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            board_selected_n <= 1'b1;
            cycle_busy       <= 1'b0;
        end else begin
            if (!slave_req.as_n)
                cycle_busy <= 1'b1;
            else if (dtack_in_n)
                cycle_busy <= 1'b0;
            if (base_match && !(slave_req.ds0_n && slave_req.ds1_n))
                board_selected_n <= 1'b0;
            else if (slave_req.ds0_n && slave_req.ds1_n && slave_req.as_n && local_ack_n)
                board_selected_n <= 1'b1;
        end
    end

    // selects; unmatched window addresses select nothing and get no ack
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            selects <= '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0};
        else
            selects <= next_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; local reset and fail bits survive onboard reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            config_reg_one <= CFG_RESET;
            config_reg_two <= CFG_RESET;
        end else begin
            if (onboard_reset)
                config_reg_one <= CFG_RESET;
            else if (!next_sel.config_reg_one_sel_n && !slave_req.write_n && !slave_req.ds0_n)
                config_reg_one <= data_in[7:0];
            if (!next_sel.config_reg_two_sel_n && !slave_req.write_n && !slave_req.ds0_n)
                config_reg_two <= data_in[7:0];
            else if (onboard_reset) begin
                config_reg_two              <= CFG_RESET;
                config_reg_two[LMR_POS]     <= config_reg_two[LMR_POS];
                config_reg_two[SFL_POS]     <= config_reg_two[SFL_POS];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            onboard_reset <= 1'b1;
        else
            onboard_reset <= config_reg_two[LMR_POS];
    end

    ////////////////////////////////////////////////////////////////////////
    // slave read data; dma byte copied to both lanes, gpib and config reads fill unused lanes with ones
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data      <= '1;
            read_data_oe_n <= 1'b1;
        end else begin
            // drive only reads that hit a decoded target; holes stay silent
            read_data_oe_n <= !(selected && slave_req.write_n &&
                !(next_sel.dma_sel_n && next_sel.gpib_sel_n && next_sel.config_reg_one_sel_n && next_sel.config_reg_two_sel_n));
            if (!next_sel.dma_sel_n)
                read_data <= {dma_ctrl_data, dma_ctrl_data};
            else if (!next_sel.gpib_sel_n)
                read_data <= {ALL_ONES_BYTE, gpib_data};
            else
                read_data <= {ALL_ONES_BYTE, ALL_ONES_BYTE};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master address latches, open while upper strobe low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            upper_latch <= '0;
            mid_latch   <= '0;
        end else if (!upper_addr_strobe_n) begin
            upper_latch <= dma_mux_bus[15:8];
            mid_latch   <= dma_mux_bus[7:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            master_addr      <= '0;
            master_am        <= AM_MASTER_DEF;
            master_iack_n    <= 1'b1;
            master_lword_n   <= 1'b1;
            master_addr_oe_n <= 1'b1;
            control_dir_out  <= 1'b0;
        end else begin
            master_addr      <= {upper_latch, mid_latch, dma_low_addr};
            master_am        <= AM_MASTER_DEF;
            master_iack_n    <= 1'b1;
            master_lword_n   <= 1'b1;
            master_addr_oe_n <= bus_owned_n;
            control_dir_out  <= !bus_owned_n;
        end
    end

    // master strobes and data; held off while old ack or error stands
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            master_write_n      <= 1'b1;
            master_ds0_n        <= 1'b1;
            master_ds1_n        <= 1'b1;
            master_ds_oe_n      <= 1'b1;
            master_data         <= '0;
            master_data_oe_n    <= 1'b1;
            bus_exception_input <= 1'b0;
        end else begin
            master_write_n   <= dma_write_n | carry_byte_force;
            master_ds0_n     <= lower_data_strobe_n | !timing_strobe_gate;
            master_ds1_n     <= upper_data_strobe_n | !timing_strobe_gate;
            master_ds_oe_n   <= bus_owned_n || !dtack_in_n || !berr_in_n;
            master_data_oe_n <= bus_owned_n || !dtack_in_n || !berr_in_n || dma_write_n;
            if (!upper_byte_select_n)
                master_data <= {gpib_data, ALL_ONES_BYTE};
            else
                master_data <= {ALL_ONES_BYTE, gpib_data};
            bus_exception_input <= !bus_owned_n && !berr_in_n;
        end
    end
endmodule

// *** vme_glue_sva.sv ***
// Purpose: port-level checks of slave decode, reset and master glue
// Assumes: one clock, reset async active high
// Notes:   delays follow the one-cycle registered outputs
module glue_sva
    import vme_glue_pkg::*;
(
    // clock and reset
    input wire logic                     clock,
    input wire logic                     reset,
    // slave side
    input wire vme_glue_pkg::slave_req_t slave_req,
    input wire logic [15:9]              base_jumpers,
    input wire logic                     local_ack_n,
    input wire logic                     board_selected_n,
    input wire vme_glue_pkg::selects_t   selects,
    input wire logic [8:1]               held_addr,
    input wire logic                     carry_byte_force,
    input wire logic [7:0]               config_reg_two,
    input wire logic                     onboard_reset,
    input wire logic                     chip_clock_tick,
    // master side
    input wire logic                     bus_owned_n,
    input wire logic                     berr_in_n,
    input wire logic                     dma_write_n,
    input wire logic                     timing_strobe_gate,
    input wire logic                     master_write_n,
    input wire logic                     master_ds0_n,
    input wire logic                     master_ds1_n,
    input wire logic                     bus_exception_input
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    property p_tick;
        chip_clock_tick |=> !chip_clock_tick ##1 chip_clock_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("chip clock not every second cycle");
    property p_match;
        $fell(board_selected_n) |-> $past(!slave_req.as_n && slave_req.iack_n && !(slave_req.ds0_n && slave_req.ds1_n)
            && (slave_req.am == AM_SHORT_SUP || slave_req.am == AM_SHORT_USER) && slave_req.addr[15:9] == base_jumpers);
    endproperty
    a_match: assert property (p_match) else $error("board selected without match");
    property p_hold;
        !board_selected_n && !(slave_req.as_n && slave_req.ds0_n && slave_req.ds1_n && local_ack_n) |=> !board_selected_n;
    endproperty
    a_hold: assert property (p_hold) else $error("board select dropped early");
    property p_rs;
        !selects.gpib_sel_n |-> selects.gpib_rs == ($past(carry_byte_force) ? AUX_MODE_SEL : $past(held_addr[3:1]));
    endproperty
    a_rs: assert property (p_rs) else $error("wrong gpib register select");
    property p_lmr;
        config_reg_two[LMR_POS] |=> onboard_reset;
    endproperty
    a_lmr: assert property (p_lmr) else $error("local reset bit ignored");
    property p_wr;
        !bus_owned_n |=> master_write_n == $past(dma_write_n || carry_byte_force);
    endproperty
    a_wr: assert property (p_wr) else $error("master write not ored");
    property p_berr;
        !bus_owned_n && !berr_in_n |=> bus_exception_input;
    endproperty
    a_berr: assert property (p_berr) else $error("bus error not passed on");
    property p_gate;
        !timing_strobe_gate |=> master_ds0_n && master_ds1_n;
    endproperty
    a_gate: assert property (p_gate) else $error("data strobe escaped gate");
    c_carry: cover property (!selects.gpib_sel_n && $past(carry_byte_force));
    c_end: cover property ($rose(board_selected_n));
    c_berr: cover property (bus_exception_input);
endmodule
bind vme_slave_decode_and_master_glue glue_sva chk (.clock, .reset, .slave_req, .base_jumpers, .local_ack_n,
    .board_selected_n, .selects, .held_addr, .carry_byte_force, .config_reg_two, .onboard_reset, .chip_clock_tick,
    .bus_owned_n, .berr_in_n, .dma_write_n, .timing_strobe_gate, .master_write_n, .master_ds0_n, .master_ds1_n,
    .bus_exception_input);

// *** vme_master_model.sv ***
// Purpose: bus master opening and closing short io slave cycles
// Assumes: tasks called just after a rising edge
// Notes:   stop raises all strobes; address, modifier and data show the inverse of their last value
module vme_master_model
    import vme_glue_pkg::*;
(
    // bus out
    output vme_glue_pkg::slave_req_t req,
    output logic [15:0]              data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        req = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 15'h0000};
        data = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // address, modifier and strobes change together and hold until stop
    task start(input logic [15:1] a, input logic [5:0] am, input logic iack_n, input logic wr_n,
        input logic [1:0] ds, input logic [15:0] d);
        req = '{1'b0, ds[0], ds[1], iack_n, wr_n, am, a};
        data = d;
    endtask
    task stop;
        req = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ~req.am, ~req.addr};
        data = ~data;
    endtask
endmodule

// *** vme_slave_decode_and_master_glue_bench.sv ***
// Purpose: directed scenarios for slave decode and master glue
// Assumes: inputs change 1 ns after the rising edge
// Notes:   master timing machine replaced by bench-driven strobes
module vme_slave_decode_and_master_glue_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import vme_glue_pkg::*;
    localparam logic [15:9] BASE = 7'h5A;
    logic        clock, reset, dtack_in_n, berr_in_n, local_ack_n, bus_owned_n, upper_addr_strobe_n;
    logic        dma_write_n, upper_data_strobe_n, lower_data_strobe_n, upper_byte_select_n;
    logic        timing_strobe_gate, carry_byte_force, board_selected_n, read_data_oe_n, onboard_reset;
    logic        chip_clock_tick, master_iack_n, master_lword_n, master_addr_oe_n, master_write_n, master_ds0_n;
    logic        master_ds1_n, master_ds_oe_n, control_dir_out, master_data_oe_n, bus_exception_input;
    logic [15:9] base_jumpers;
    logic [15:0] dma_mux_bus, data_in, read_data, master_data;
    logic [7:1]  dma_low_addr;
    logic [7:0]  dma_ctrl_data, gpib_data, config_reg_one, config_reg_two;
    logic [8:1]  held_addr;
    logic [23:1] master_addr;
    logic [5:0]  master_am;
    slave_req_t  slave_req;
    selects_t    selects;
    int          fail_count, n_checks, cycles;
    vme_master_model m (.req(slave_req), .data(data_in));
    vme_slave_decode_and_master_glue DUT (.clock, .reset, .slave_req, .data_in, .dtack_in_n, .berr_in_n,
        .base_jumpers, .local_ack_n, .bus_owned_n, .upper_addr_strobe_n, .dma_mux_bus, .dma_low_addr,
        .dma_write_n, .upper_data_strobe_n, .lower_data_strobe_n, .upper_byte_select_n, .timing_strobe_gate,
        .carry_byte_force, .dma_ctrl_data, .gpib_data, .board_selected_n, .selects, .held_addr, .read_data,
        .read_data_oe_n, .config_reg_one, .config_reg_two, .onboard_reset, .chip_clock_tick, .master_addr,
        .master_am, .master_iack_n, .master_lword_n, .master_addr_oe_n, .master_write_n, .master_ds0_n,
        .master_ds1_n, .master_ds_oe_n, .control_dir_out, .master_data, .master_data_oe_n,
        .bus_exception_input);
    ////////////////////////////////////////////////////////////////
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // bad modifier, iack, wrong base, no data strobe: never selected
    task t_nomatch;
        for (int i = 0; i < 4; i++) begin
            m.start({i == 2 ? ~BASE : BASE, 8'h25}, i == 0 ? AM_MASTER_DEF : AM_SHORT_SUP, i != 1, 1'b1,
                i == 3 ? 2'b11 : 2'b00, 16'h0000);
            step(3);
            chk(board_selected_n, 1'b1);
            m.stop();
            step(3);
        end
        $display("nomatch done");
    endtask
    // select must outlive the strobes while the board ack stands
    task t_dma;
        m.start({BASE, 8'h25}, AM_SHORT_USER, 1'b1, 1'b1, 2'b00, 16'h0000);
        step(4);
        chk(board_selected_n, 1'b0);
        chk(selects.dma_sel_n, 1'b0);
        chk(selects.gpib_sel_n, 1'b1);
        chk(held_addr, 8'h25);
        chk({read_data_oe_n, read_data}, {1'b0, 16'h9696});
        local_ack_n = 1'b0;
        m.stop();
        step(3);
        chk(board_selected_n, 1'b0);
        local_ack_n = 1'b1;
        step(3);
        chk(board_selected_n, 1'b1);
        $display("dma done");
    endtask
    task t_gpib;
        for (int i = 0; i < 10; i++) begin
            carry_byte_force = (i == 8);
            m.start({BASE, 5'h11, i[2:0]}, AM_SHORT_SUP, 1'b1, 1'b1, i == 9 ? 2'b01 : 2'b10, 16'h0000);
            step(4);
            chk(selects.gpib_sel_n, i == 9);
            chk(selects.dma_sel_n & selects.config_reg_one_sel_n & selects.config_reg_two_sel_n, 1'b1);
            if (i < 9) chk(selects.gpib_rs, i == 8 ? AUX_MODE_SEL : i[2:0]);
            if (i < 8) chk(read_data, {8'hFF, gpib_data});
            chk(read_data_oe_n, i == 9);
            m.stop();
            step(3);
        end
        carry_byte_force = 1'b0;
        $display("gpib done");
    endtask
    task cfg_cycle(input logic [8:1] a, input logic wr_n, input logic [15:0] d);
        m.start({BASE, a}, AM_SHORT_SUP, 1'b1, wr_n, 2'b00, d);
        step(4);
        chk({selects.config_reg_one_sel_n, selects.config_reg_two_sel_n}, a[2] ? 2'b10 : 2'b01);
        if (wr_n) chk({read_data_oe_n, read_data}, {1'b0, 16'hFFFF});
        else chk(read_data_oe_n, 1'b1);
        m.stop();
        step(3);
    endtask
    task t_cfg;
        cfg_cycle(8'h80, 1'b0, 16'h3CA5);
        chk(config_reg_one, 8'hA5);
        cfg_cycle(8'h82, 1'b0, 16'hC307);
        chk(onboard_reset, 1'b1);
        chk(config_reg_one, 8'h00);
        cfg_cycle(8'h82, 1'b1, 16'h0000);
        chk(config_reg_two, 8'h03);
        cfg_cycle(8'h82, 1'b0, 16'h0000);
        chk(onboard_reset, 1'b0);
        $display("config done");
    endtask
    task t_master;
        {bus_owned_n, upper_addr_strobe_n, dma_mux_bus, dma_low_addr} = {2'b00, 16'hBEEF, 7'h55};
        step(2);
        {upper_addr_strobe_n, dma_mux_bus} = {1'b1, 16'h1234};
        step(2);
        chk(master_addr, {16'hBEEF, 7'h55});
        chk({master_addr_oe_n, control_dir_out, master_iack_n, master_lword_n, master_am},
            {4'b0111, AM_MASTER_DEF});
        for (int i = 0; i < 4; i++) begin
            {dma_write_n, carry_byte_force} = i[1:0];
            step(2);
            chk(master_write_n, i[1] | i[0]);
        end
        {dma_write_n, carry_byte_force, upper_data_strobe_n, lower_data_strobe_n} = 4'b0000;
        step(2);
        chk({master_ds1_n, master_ds0_n}, 2'b11);
        timing_strobe_gate = 1'b1;
        step(2);
        chk({master_ds1_n, master_ds0_n}, 2'b00);
        dtack_in_n = 1'b0;
        step(2);
        chk({master_ds_oe_n, master_data_oe_n}, 2'b11);
        {dtack_in_n, upper_byte_select_n} = 2'b10;
        step(2);
        chk({master_ds_oe_n, master_data_oe_n}, 2'b00);
        chk(master_data[15:8], gpib_data);
        {upper_byte_select_n, berr_in_n} = 2'b10;
        step(2);
        chk({master_ds_oe_n, master_data_oe_n}, 2'b11);
        chk(master_data[7:0], gpib_data);
        chk(bus_exception_input, 1'b1);
        bus_owned_n = 1'b1;
        step(2);
        chk(bus_exception_input, 1'b0);
        {berr_in_n, timing_strobe_gate, upper_data_strobe_n, lower_data_strobe_n} = 4'b1011;
        $display("master done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        {reset, dtack_in_n, berr_in_n, local_ack_n, bus_owned_n, upper_addr_strobe_n} = 6'h3F;
        {dma_write_n, upper_data_strobe_n, lower_data_strobe_n, upper_byte_select_n} = 4'hF;
        {timing_strobe_gate, carry_byte_force, dma_mux_bus, dma_low_addr} = 25'h000_0000;
        {base_jumpers, dma_ctrl_data, gpib_data} = {BASE, 8'h96, 8'h6B};
        {fail_count, n_checks, cycles} = 96'h0;
        step(4);
        chk({config_reg_one, config_reg_two, onboard_reset, board_selected_n}, 18'h0_0003);
        chk(master_am, AM_MASTER_DEF);
        reset = 1'b0;
        step(2);
        chk(onboard_reset, 1'b0);
        $display("reset done");
        t_nomatch();
        t_dma();
        t_gpib();
        t_cfg();
        t_master();
        end_sim();
    end
endmodule
